// ### rtl/asrd_pkg.sv
// package: constants and carrier types of the sample rate divider
package asrd_pkg;

  localparam int unsigned PRESCALE_W    = 2;
  localparam int unsigned OSR_SEL_W     = 3;
  localparam int unsigned CAL_W         = 24;
  localparam int unsigned CNT_W         = 17;
  localparam int unsigned CHANNELS      = 2;

  localparam logic [1:0]  PRESCALE_RST  = 2'h0;
  localparam logic [2:0]  OSR_SEL_RST   = 3'h3;
  localparam int unsigned OSR_BASE      = 32;
  localparam int unsigned SAMPLE_DIV    = 4;
  localparam int unsigned FASTEST_WORD  = 128;

  typedef struct packed {
    logic [PRESCALE_W-1:0] prescale_sel;
    logic [OSR_SEL_W-1:0]  oversampling_ratio_sel;
  } asrd_cfg_type;

  typedef struct packed {
    logic signed [CAL_W-1:0] offset_correction_word;
    logic signed [CAL_W-1:0] gain_correction_word;
  } asrd_cal_type;

  typedef struct packed {
    logic [2:0]       pre_cnt;
    logic [1:0]       quarter_cnt;
    logic [11:0]      osr_cnt;
    asrd_cfg_type     cfg;
    logic             analog_clock;
    logic             sample_tick;
    logic             output_rate_clock;
    logic [5:0]       low_cnt;
    logic             data_ready_pulse_n;
  } asrd_div_state_type;

endpackage

// ### rtl/asrd_corrector.sv
// module: per-channel offset and gain correction of one conversion result
module asrd_corrector
  import asrd_pkg::*;
(
  input  wire logic                    clk_sys,     // master clock
  input  wire logic                    rst,         // synchronous reset
  input  wire logic                    load,        // take a new raw result
  input  wire logic signed [CAL_W-1:0] raw,         // raw conversion result
  input  wire asrd_pkg::asrd_cal_type  cal,         // this channel's correction words
  output logic signed [CAL_W-1:0]      corrected    // corrected result
);

  // gain word is unity plus a signed fraction in 2^-23 units
  logic signed [CAL_W:0]     sum;
  logic signed [2*CAL_W+1:0] prod;
  logic signed [CAL_W-1:0]   res_r;
  logic signed [CAL_W-1:0]   res_nxt;

  always_comb begin
    sum     = $signed({raw[CAL_W-1], raw}) + $signed({cal.offset_correction_word[CAL_W-1],
              cal.offset_correction_word});
    prod    = sum * $signed({1'b0, {CAL_W{1'b0}}} + (CAL_W+1)'(1 << (CAL_W-1))
              + $signed({cal.gain_correction_word[CAL_W-1], cal.gain_correction_word}));
    res_nxt = prod[2*CAL_W-2:CAL_W-1];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      res_r <= '0;
    end else if (load) begin
      res_r <= res_nxt;
    end
  end

  assign corrected = res_r;

endmodule

// ### rtl/asrd_divider.sv
// module: clock divider chain and data-ready pulse of a two-channel front end
// ==========================================
module asrd_divider
  import asrd_pkg::*;
(
  input  wire logic                           clk_sys,            // master clock
  input  wire logic                           rst,                // synchronous reset
  input  wire logic [PRESCALE_W-1:0]          prescale_sel,       // analog clock prescale code
  input  wire logic [OSR_SEL_W-1:0]           oversampling_ratio_sel, // ratio code
  input  wire asrd_pkg::asrd_cal_type         cal_ch0,            // channel 0 correction
  input  wire asrd_pkg::asrd_cal_type         cal_ch1,            // channel 1 correction
  input  wire logic signed [CAL_W-1:0]        raw_ch0,            // channel 0 raw result
  input  wire logic signed [CAL_W-1:0]        raw_ch1,            // channel 1 raw result
  output logic                                analog_clock,       // divided analog clock
  output logic                                sample_clock_tick,  // one pulse per sample
  output logic                                output_rate_clock,  // one pulse per output word
  output logic                                data_ready_pulse_n, // active-low data ready
  output logic signed [CAL_W-1:0]             result_ch0,         // corrected channel 0
  output logic signed [CAL_W-1:0]             result_ch1          // corrected channel 1
);

  // ==========================================
  // helpers
  function automatic logic [3:0] prescale_of(input logic [1:0] code);
    prescale_of = 4'(1 << code);
  endfunction

  function automatic logic [12:0] ratio_of(input logic [2:0] code);
    ratio_of = 13'(OSR_BASE << code);
  endfunction

  // ==========================================
  // divider state
  asrd_div_state_type st_r;
  asrd_div_state_type st_nxt;
  logic               pre_wrap;
  logic               adv_sample;
  logic               adv_rate;

  always_comb begin
    st_nxt      = st_r;
    pre_wrap    = (st_r.pre_cnt == 3'(prescale_of(st_r.cfg.prescale_sel) - 4'h1));
    adv_sample  = pre_wrap && (st_r.quarter_cnt == 2'(SAMPLE_DIV - 1));
    adv_rate    = adv_sample &&
                  (st_r.osr_cnt == 12'(ratio_of(st_r.cfg.oversampling_ratio_sel) - 13'h1));
    st_nxt.pre_cnt     = pre_wrap ? 3'h0 : st_r.pre_cnt + 3'h1;
    if (pre_wrap) begin
      st_nxt.quarter_cnt = st_r.quarter_cnt + 2'h1;
    end
    // analog clock high for the first half of its period
    st_nxt.analog_clock = (st_nxt.pre_cnt < 3'(prescale_of(st_r.cfg.prescale_sel) >> 1)) ||
                          (st_r.cfg.prescale_sel == 2'h0 && !st_r.analog_clock);
    if (adv_sample) begin
      st_nxt.osr_cnt = adv_rate ? 12'h000 : st_r.osr_cnt + 12'h001;
    end
    st_nxt.sample_tick       = adv_sample;
    st_nxt.output_rate_clock = adv_rate;
    // data ready low for one sample period, counted in master clocks
    // width follows the prescale that the coming sample period runs at
    if (adv_rate) begin
      st_nxt.data_ready_pulse_n = 1'b0;
      st_nxt.low_cnt = 6'(SAMPLE_DIV * prescale_of(prescale_sel) - 1);
    end else if (st_r.low_cnt != 6'h00) begin
      st_nxt.low_cnt = st_r.low_cnt - 6'h01;
    end else begin
      st_nxt.data_ready_pulse_n = 1'b1;
    end
    // new settings take effect at an output word boundary
    if (adv_rate) begin
      st_nxt.cfg.prescale_sel           = prescale_sel;
      st_nxt.cfg.oversampling_ratio_sel = oversampling_ratio_sel;
      st_nxt.pre_cnt                    = 3'h0;
      st_nxt.quarter_cnt                = 2'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r                            <= '0;
      st_r.cfg.prescale_sel           <= PRESCALE_RST;
      st_r.cfg.oversampling_ratio_sel <= OSR_SEL_RST;
      st_r.data_ready_pulse_n         <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign analog_clock       = st_r.analog_clock;
  assign sample_clock_tick  = st_r.sample_tick;
  assign output_rate_clock  = st_r.output_rate_clock;
  assign data_ready_pulse_n = st_r.data_ready_pulse_n;

  // ==========================================
  // per-channel correction, loaded on each output word
  asrd_corrector u_corr0 (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .load      (adv_rate),
    .raw       (raw_ch0),
    .cal       (cal_ch0),
    .corrected (result_ch0)
  );

  asrd_corrector u_corr1 (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .load      (adv_rate),
    .raw       (raw_ch1),
    .cal       (cal_ch1),
    .corrected (result_ch1)
  );

  // ==========================================
  // checks
  logic [12:0] gap_cnt;
  logic        seen_tick;
  always_ff @(posedge clk_sys) begin
    if (rst || output_rate_clock) begin
      gap_cnt   <= 13'h0001;
      seen_tick <= !rst;
    end else if (gap_cnt != 13'h1FFF) begin
      gap_cnt <= gap_cnt + 13'h0001;
    end
  end

  reset_cfg_a: assert property (@(posedge clk_sys) $fell(rst) |->
    st_r.cfg.oversampling_ratio_sel == 3'h3 && st_r.cfg.prescale_sel == 2'h0)
    else $error("reset settings wrong");

  fastest_rate_a: assert property (@(posedge clk_sys) disable iff (rst)
    output_rate_clock && st_r.cfg == '0 && $past(st_r.cfg) == '0 && seen_tick |->
    ##128 output_rate_clock)
    else $error("fastest word spacing not 128");

  no_early_tick_a: assert property (@(posedge clk_sys) disable iff (rst)
    output_rate_clock && seen_tick |-> gap_cnt >= 13'h0080)
    else $error("output ticks too close");

  sample_quarter_a: assert property (@(posedge clk_sys) disable iff (rst)
    sample_clock_tick && st_r.cfg.prescale_sel == 2'h0 |->
    ##1 !sample_clock_tick [*3] ##1 (sample_clock_tick || output_rate_clock ||
    $past(output_rate_clock)))
    else $error("sample tick spacing wrong at unity prescale");

  dr_width_a: assert property (@(posedge clk_sys) disable iff (rst)
    output_rate_clock && st_r.cfg.prescale_sel == 2'h0 |->
    !data_ready_pulse_n [*4] ##1 data_ready_pulse_n)
    else $error("data ready width not one sample period");

  dr_cause_a: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(data_ready_pulse_n) |-> output_rate_clock)
    else $error("data ready fell without a tick");

  analog_div2_a: assert property (@(posedge clk_sys) disable iff (rst)
    st_r.cfg.prescale_sel == 2'h1 && $past(st_r.cfg.prescale_sel) == 2'h1 &&
    !output_rate_clock && !$past(output_rate_clock) |->
    analog_clock != $past(analog_clock))
    else $error("analog clock not master over two");

  corr_load_a: assert property (@(posedge clk_sys) disable iff (rst)
    !$past(adv_rate) && !$past(rst) |-> $stable(result_ch0) && $stable(result_ch1))
    else $error("result changed without output tick");

endmodule

// ### testbench/asrd_host_model.sv
// host model: reads both channel words on each data-ready fall
module asrd_host_model
  import asrd_pkg::*;
(
  input  wire logic                    clk_sys,    // master clock
  input  wire logic                    rst,        // synchronous reset
  input  wire logic                    ready_n,    // data ready, active low
  input  wire logic signed [CAL_W-1:0] result_ch0, // channel 0 word
  input  wire logic signed [CAL_W-1:0] result_ch1, // channel 1 word
  output logic signed [CAL_W-1:0]      word_ch0,   // last word read, ch 0
  output logic signed [CAL_W-1:0]      word_ch1    // last word read, ch 1
);
  logic ready_n_r;
  // the pulse is not latched: act on the falling edge only
  always @(posedge clk_sys) begin
    if (rst) begin
      ready_n_r <= 1'b1;
      word_ch0  <= 24'h000000;
      word_ch1  <= 24'h000000;
    end else begin
      ready_n_r <= ready_n;
      if (ready_n_r && !ready_n) begin
        word_ch0 <= result_ch0;
        word_ch1 <= result_ch1;
      end
    end
  end
endmodule

// ### testbench/test_adc_sample_rate_divider.sv
// testbench: divider rates, data-ready width and channel correction
module test_adc_sample_rate_divider;
  timeunit 1ns;
  timeprecision 1ps;
  import asrd_pkg::*;
  logic                    clk_sys = 1'b0;
  logic                    rst = 1'b1;
  logic [1:0]              prescale_sel = 2'h0;
  logic [2:0]              oversampling_ratio_sel = 3'h0;
  asrd_cal_type            cal_ch0 = '{24'h000018, 24'h400000};
  asrd_cal_type            cal_ch1 = '{24'hFFFFD0, 24'hE00000};
  logic signed [CAL_W-1:0] raw_ch0 = 24'h0003E8;
  logic signed [CAL_W-1:0] raw_ch1 = 24'hFFF830;
  logic                    analog_clock;
  logic                    sample_clock_tick;
  logic                    output_rate_clock;
  logic                    data_ready_pulse_n;
  logic signed [CAL_W-1:0] result_ch0;
  logic signed [CAL_W-1:0] result_ch1;
  logic signed [CAL_W-1:0] word_ch0;
  logic signed [CAL_W-1:0] word_ch1;
  int                      error_cnt = 0;
  int                      samples_checked = 0;
  int                      cycles = 0;

  always #20 clk_sys = ~clk_sys;

  asrd_divider DUT (.clk_sys(clk_sys), .rst(rst), .prescale_sel(prescale_sel),
    .oversampling_ratio_sel(oversampling_ratio_sel), .cal_ch0(cal_ch0), .cal_ch1(cal_ch1),
    .raw_ch0(raw_ch0), .raw_ch1(raw_ch1), .analog_clock(analog_clock),
    .sample_clock_tick(sample_clock_tick), .output_rate_clock(output_rate_clock),
    .data_ready_pulse_n(data_ready_pulse_n), .result_ch0(result_ch0), .result_ch1(result_ch1));
  asrd_host_model host (.clk_sys(clk_sys), .rst(rst), .ready_n(data_ready_pulse_n),
    .result_ch0(result_ch0), .result_ch1(result_ch1), .word_ch0(word_ch0), .word_ch1(word_ch1));

  // ==========================================
  // checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 80000) begin
      error_cnt++;
      close_out();
    end
  end

  function automatic logic [23:0] fix(input logic signed [CAL_W-1:0] raw, input asrd_cal_type c);
    longint s;
    s = (longint'(raw) + longint'(c.offset_correction_word))
        * ((longint'(1) << 23) + longint'(c.gain_correction_word));
    return 24'(s >>> 23);
  endfunction

  // ==========================================
  // scenarios
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (output_rate_clock !== 1'b1 && n < 20000);
    check(32'({output_rate_clock, data_ready_pulse_n}), 32'h00000002);
  endtask

  // new codes apply at the next tick; the period after it is measured
  task automatic run_rate(input logic [1:0] p, input logic [2:0] o);
    int n;
    int lo;
    int sc;
    @(posedge clk_sys);
    prescale_sel <= p;
    oversampling_ratio_sel <= o;
    wait_tick(n);
    lo = 0;
    sc = 0;
    n = 0;
    do begin
      lo += (data_ready_pulse_n === 1'b0);
      sc += (sample_clock_tick === 1'b1);
      n++;
      @(negedge clk_sys);
    end while (output_rate_clock !== 1'b1 && n < 20000);
    check(n, 4 * (1 << p) * (32 << o));
    check(lo, 4 << p);
    check(sc, 32 << o);
    check({8'h00, result_ch0}, {8'h00, fix(raw_ch0, cal_ch0)});
    check({8'h00, result_ch1}, {8'h00, fix(raw_ch1, cal_ch1)});
    check({8'h00, word_ch0}, {8'h00, fix(raw_ch0, cal_ch0)});
    check({8'h00, word_ch1}, {8'h00, fix(raw_ch1, cal_ch1)});
  endtask

  initial begin
    int n;
    repeat (4) @(negedge clk_sys);
    check(32'({output_rate_clock, data_ready_pulse_n}), 32'h00000001);
    @(posedge clk_sys);
    rst <= 1'b0;
    wait_tick(n);
    check(32'(n >= 1020 && n <= 1030), 32'h00000001);
    for (int i = 0; i < 4; i++) begin
      run_rate(2'(i), 3'h0);
    end
    for (int i = 7; i >= 0; i--) begin
      run_rate(2'h0, 3'(i));
    end
    close_out();
  end
endmodule
